// ---- core/ppi_axil.sv ----
// AXI4-Lite slave front end with one-word register strobes
`timescale 1ns/100ps
`default_nettype none
module ppi_axil #(
  parameter int AW = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wrStb,
  output logic [AW-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrOk,
  output logic rdStb,
  output logic [AW-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdOk
);
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [AW-1:0] awA, next_awA;
  logic [31:0] wD, next_wD;
  logic [3:0] wS, next_wS;
  logic bV, next_bV, rV, next_rV, arRdy, next_arRdy;
  logic awRdy, next_awRdy, wRdy, next_wRdy;
  logic [1:0] bR, next_bR, rR, next_rR;
  logic [31:0] rD, next_rD;
  // ----------------------------------------------------------------
  // Write path: catch address and data in any order, then respond
  // ----------------------------------------------------------------
  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awA = awA;
    next_wD = wD;
    next_wS = wS;
    next_bV = bV;
    next_bR = bR;
    if (s_axi_awvalid && !awHeld && !bV) begin
      next_awHeld = 1'b1;
      next_awA = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld && !bV) begin
      next_wHeld = 1'b1;
      next_wD = s_axi_wdata;
      next_wS = s_axi_wstrb;
    end
    if (awHeld && wHeld) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bV = 1'b1;
      next_bR = wrOk ? ppi_pkg::RESP_OKAY : ppi_pkg::RESP_SLVERR;
    end
    if (bV && s_axi_bready) begin
      next_bV = 1'b0;
    end
    // Ready flags come from registers so the port is glitch free
    next_awRdy = !next_awHeld && !next_bV;
    next_wRdy = !next_wHeld && !next_bV;
  end
  assign wrStb = awHeld && wHeld;
  assign wrAddr = awA;
  assign wrData = wD;
  assign wrStrb = wS;
  // ----------------------------------------------------------------
  // Read path: one cycle accept, registered data
  // ----------------------------------------------------------------
  assign rdStb = s_axi_arvalid && arRdy;
  assign rdAddr = s_axi_araddr;
  always_comb begin
    next_rV = rV;
    next_rD = rD;
    next_rR = rR;
    next_arRdy = arRdy;
    if (rdStb) begin
      next_arRdy = 1'b0;
      next_rV = 1'b1;
      next_rD = rdOk ? rdData : 32'h0000_0000;
      next_rR = rdOk ? ppi_pkg::RESP_OKAY : ppi_pkg::RESP_SLVERR;
    end else if (rV && s_axi_rready) begin
      next_rV = 1'b0;
      next_arRdy = 1'b1;
    end
  end
  // Register stage for both paths
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awA <= '0;
      wD <= 32'h0000_0000;
      wS <= 4'h0;
      bV <= 1'b0;
      bR <= 2'h0;
      rV <= 1'b0;
      rD <= 32'h0000_0000;
      rR <= 2'h0;
      arRdy <= 1'b1;
      awRdy <= 1'b1;
      wRdy <= 1'b1;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awA <= next_awA;
      wD <= next_wD;
      wS <= next_wS;
      bV <= next_bV;
      bR <= next_bR;
      rV <= next_rV;
      rD <= next_rD;
      rR <= next_rR;
      arRdy <= next_arRdy;
      awRdy <= next_awRdy;
      wRdy <= next_wRdy;
    end
  end
  assign s_axi_awready = awRdy;
  assign s_axi_wready = wRdy;
  assign s_axi_bvalid = bV;
  assign s_axi_bresp = bR;
  assign s_axi_arready = arRdy;
  assign s_axi_rvalid = rV;
  assign s_axi_rdata = rD;
  assign s_axi_rresp = rR;
endmodule // ppi_axil
`default_nettype wire

// ---- core/ppi_match.sv ----
// Masked pattern comparator for the input port
`timescale 1ns/100ps
`default_nettype none
module ppi_match #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] portIn,
  input wire logic [WIDTH-1:0] compare,
  input wire logic [WIDTH-1:0] mask,
  output logic hit
);
  logic [WIDTH-1:0] bitOk;
  // ----------------------------------------------------------------
  // Per-bit compare
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gBit
      // Bit i is input i; unmasked bits always agree
      assign bitOk[i] = ~mask[i] | (portIn[i] == compare[i]);
    end
  endgenerate
  // Zero mask never hits
  assign hit = (&bitOk) & (|mask);
endmodule // ppi_match
`default_nettype wire

// ---- core/ppi_pkg.sv ----
// Constants and types shared by the polled pattern interrupt unit
package ppi_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int ADDR_W = 4;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CFG = 4'h0;   // Compare [7:0], mask [15:8]
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h4;  // Armed, pending, in handler, port
  localparam logic [ADDR_W-1:0] OFS_IRQST = 4'h8; // Sticky events, clear on read
  localparam logic [ADDR_W-1:0] OFS_IRQMSK = 4'hc; // Event mask
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_CMP_LSB = 0;
  localparam int CFG_MSK_LSB = 8;
  localparam int ST_ARMED = 0;
  localparam int ST_PEND = 1;
  localparam int ST_INHDL = 2;
  localparam int ST_PORT_LSB = 8;
  localparam int EV_TAKEN = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_W = 2;
  // ----------------------------------------------------------------
  // Reset values and bus responses
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] RST_BYTE = 8'h00;
  localparam logic [EV_W-1:0] RST_EV = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Unit state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PPI_IDLE, PPI_ARMED, PPI_HANDLER} ppi_state_t;
endpackage : ppi_pkg

// ---- core/ppi_top.sv ----
// Polled pattern interrupt unit: core handshake, match and registers
`timescale 1ns/100ps
`default_nettype none
// Function
// - A hit is declared when the masked port bits equal the masked compare bits.
// - Port bits with a zero mask bit never affect the hit.
// - Port, mask and compare are eight bits, bit 0 being input 0 and bit 7 input 7.
// - The hit is only looked at on command boundaries, note gaps and during delays.
// - A hit at a poll point forces a call into the handler at once.
// - One compare and mask pair is held, and a new write replaces it; a write in the cycle a call is taken is dropped.
// - A zero mask disables the unit so nothing can trigger.
// - Taking an interrupt disarms the unit until software configures it again.
// - A configuration written in the handler waits and arms only at the return; one written in the return cycle is dropped.
// - If re-armed and still matching at the return, a new interrupt is taken at once.
// - After the return execution resumes at the command after the interrupted one.
// - An interrupted pause, wait, play or tune drops its remaining delay.
module ppi_top #(
  parameter int PORT_W = ppi_pkg::PORT_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Input pins and core handshake
  input wire logic [PORT_W-1:0] inPort,
  input wire logic pollCmd,
  input wire logic pollNote,
  input wire logic delayActive,
  input wire logic handlerReturn,
  output logic intCall,
  output logic delayAbort,
  output logic armed,
  output logic irq,
  // AXI4-Lite
  input wire logic [ppi_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ppi_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ppi_pkg::ppi_state_t state, next_state;
  logic [PORT_W-1:0] cmpVal, next_cmpVal, mskVal, next_mskVal;
  logic [PORT_W-1:0] pendCmp, next_pendCmp, pendMsk, next_pendMsk;
  logic pend, next_pend;
  logic next_intCall, next_delayAbort, next_armed, next_irq;
  logic [ppi_pkg::EV_W-1:0] evStat, next_evStat, evMask, next_evMask;
  logic hit, pollNow, take, cfgWr;
  logic wrStb, rdStb, wrOk, rdOk;
  logic [ppi_pkg::ADDR_W-1:0] wrAddr, rdAddr;
  logic [31:0] wrData, rdData;
  logic [3:0] wrStrb;
  logic [ppi_pkg::EV_W-1:0] evSet;

  // ----------------------------------------------------------------
  // Bus slave and comparator
  // ----------------------------------------------------------------
  ppi_axil #(.AW(ppi_pkg::ADDR_W)) uBus (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrStb(wrStb),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(wrOk),
    .rdStb(rdStb),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  ppi_match #(.WIDTH(PORT_W)) uMatch (
    .portIn(inPort),
    .compare(cmpVal),
    .mask(mskVal),
    .hit(hit)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wrOk = (wrAddr == ppi_pkg::OFS_CFG) || (wrAddr == ppi_pkg::OFS_IRQMSK) ||
                (wrAddr == ppi_pkg::OFS_STAT) || (wrAddr == ppi_pkg::OFS_IRQST);
  assign rdOk = wrOk_rd(rdAddr);
  assign cfgWr = wrStb && (wrAddr == ppi_pkg::OFS_CFG);
  // Poll points only, and never while the call is being issued
  assign pollNow = (pollCmd || pollNote || delayActive) && !intCall;
  assign take = (state == ppi_pkg::PPI_ARMED) && hit && pollNow;

  function automatic logic wrOk_rd(input logic [ppi_pkg::ADDR_W-1:0] a);
    wrOk_rd = (a == ppi_pkg::OFS_CFG) || (a == ppi_pkg::OFS_STAT) ||
              (a == ppi_pkg::OFS_IRQST) || (a == ppi_pkg::OFS_IRQMSK);
  endfunction

  // Read data mux
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (rdAddr)
      ppi_pkg::OFS_CFG: begin
        rdData[ppi_pkg::CFG_CMP_LSB +: PORT_W] = pend ? pendCmp : cmpVal;
        rdData[ppi_pkg::CFG_MSK_LSB +: PORT_W] = pend ? pendMsk : mskVal;
      end
      ppi_pkg::OFS_STAT: begin
        rdData[ppi_pkg::ST_ARMED] = armed;
        rdData[ppi_pkg::ST_PEND] = pend;
        rdData[ppi_pkg::ST_INHDL] = (state == ppi_pkg::PPI_HANDLER);
        rdData[ppi_pkg::ST_PORT_LSB +: PORT_W] = inPort;
      end
      ppi_pkg::OFS_IRQST: rdData[ppi_pkg::EV_W-1:0] = evStat;
      ppi_pkg::OFS_IRQMSK: rdData[ppi_pkg::EV_W-1:0] = evMask;
      default: rdData = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Arming state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cmpVal = cmpVal;
    next_mskVal = mskVal;
    next_pendCmp = pendCmp;
    next_pendMsk = pendMsk;
    next_pend = pend;
    next_intCall = 1'b0;
    next_delayAbort = 1'b0;
    unique case (state)
      ppi_pkg::PPI_IDLE, ppi_pkg::PPI_ARMED: begin
        if (take) begin
          next_state = ppi_pkg::PPI_HANDLER;
          next_intCall = 1'b1;
          next_delayAbort = delayActive || pollNote;
        end else if (cfgWr && wrStrb[0] && wrStrb[1]) begin
          // New pair replaces the old one; zero mask disarms
          next_cmpVal = wrData[ppi_pkg::CFG_CMP_LSB +: PORT_W];
          next_mskVal = wrData[ppi_pkg::CFG_MSK_LSB +: PORT_W];
          next_state = (|wrData[ppi_pkg::CFG_MSK_LSB +: PORT_W]) ?
                       ppi_pkg::PPI_ARMED : ppi_pkg::PPI_IDLE;
        end
      end
      ppi_pkg::PPI_HANDLER: begin
        if (cfgWr && wrStrb[0] && wrStrb[1]) begin
          // Held back until the return
          next_pendCmp = wrData[ppi_pkg::CFG_CMP_LSB +: PORT_W];
          next_pendMsk = wrData[ppi_pkg::CFG_MSK_LSB +: PORT_W];
          next_pend = 1'b1;
        end
        if (handlerReturn) begin
          // Core resumes at the next command after the return
          next_pend = 1'b0;
          if (pend) begin
            next_cmpVal = pendCmp;
            next_mskVal = pendMsk;
            next_state = (|pendMsk) ? ppi_pkg::PPI_ARMED : ppi_pkg::PPI_IDLE;
          end else begin
            next_state = ppi_pkg::PPI_IDLE;
          end
        end
      end
    endcase
  end
  // Armed output; the command resumed after the return is a poll point, so a live hit fires next
  assign next_armed = (next_state == ppi_pkg::PPI_ARMED);

  // ----------------------------------------------------------------
  // Event status and interrupt output
  // ----------------------------------------------------------------
  assign evSet = {next_delayAbort, next_intCall};
  always_comb begin
    next_evStat = evStat;
    next_evMask = evMask;
    if (rdStb && rdAddr == ppi_pkg::OFS_IRQST) begin
      next_evStat = '0;
    end
    next_evStat = next_evStat | evSet; // Set wins over clear
    if (wrStb && wrAddr == ppi_pkg::OFS_IRQMSK && wrStrb[0]) begin
      next_evMask = wrData[ppi_pkg::EV_W-1:0];
    end
    next_irq = |(next_evStat & next_evMask);
  end

  // Register stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ppi_pkg::PPI_IDLE;
      cmpVal <= ppi_pkg::RST_BYTE;
      mskVal <= ppi_pkg::RST_BYTE;
      pendCmp <= ppi_pkg::RST_BYTE;
      pendMsk <= ppi_pkg::RST_BYTE;
      pend <= 1'b0;
      intCall <= 1'b0;
      delayAbort <= 1'b0;
      armed <= 1'b0;
      evStat <= ppi_pkg::RST_EV;
      evMask <= ppi_pkg::RST_EV;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      cmpVal <= next_cmpVal;
      mskVal <= next_mskVal;
      pendCmp <= next_pendCmp;
      pendMsk <= next_pendMsk;
      pend <= next_pend;
      intCall <= next_intCall;
      delayAbort <= next_delayAbort;
      armed <= next_armed;
      evStat <= next_evStat;
      evMask <= next_evMask;
      irq <= next_irq;
    end
  end
endmodule // ppi_top
`default_nettype wire

// ---- dv/ppi_core_model.sv ----
// Behavioural execution core that makes poll points and runs the handler
`timescale 1ns/100ps
`default_nettype none
module ppi_core_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic intCall,
  input wire logic delayAbort,
  input wire logic [1:0] mode,
  input wire logic [7:0] hdlLen,
  output logic pollCmd,
  output logic pollNote,
  output logic delayActive,
  output logic handlerReturn
);
  logic inHdl;
  logic resume;
  logic [7:0] left;
  // Handler runs hdlLen+1 cycles after a call, then returns once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inHdl <= 1'b0;
      resume <= 1'b0;
      left <= 8'h00;
      handlerReturn <= 1'b0;
    end else begin
      handlerReturn <= !intCall && inHdl && left == 8'h00;
      resume <= handlerReturn;
      inHdl <= intCall || (inHdl && left != 8'h00);
      left <= intCall ? hdlLen : left - 8'h01;
    end
  end
  // Commands go on inside the handler; a delay is dropped on abort
  assign pollCmd = mode == 2'd1 || resume;
  assign pollNote = mode == 2'd2 && !inHdl;
  assign delayActive = mode == 2'd3 && !inHdl && !delayAbort;
endmodule // ppi_core_model
`default_nettype wire

// ---- dv/ppi_top_assertions.sv ----
// Port-level checks of the polled pattern interrupt unit
`timescale 1ns/100ps
`default_nettype none
module ppi_top_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pollCmd,
  input wire logic pollNote,
  input wire logic delayActive,
  input wire logic handlerReturn,
  input wire logic intCall,
  input wire logic delayAbort,
  input wire logic armed,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Start of one handler call
  sequence s_call;
    !intCall ##1 intCall;
  endsequence
  a_call_pulse: assert property (s_call |=> !intCall) else $error("call pulse too long");
  a_hdl_quiet: assert property (s_call |=> !armed) else $error("armed early in handler");
  a_call_disarm: assert property (intCall |-> !armed) else $error("armed with call");
  a_call_cause: assert property (intCall |-> $past(armed) && $past(pollCmd || pollNote || delayActive))
    else $error("call without armed poll");
  a_abort_pair: assert property (delayAbort |-> intCall) else $error("abort without call");
  a_abort_cause: assert property (intCall |-> delayAbort == $past(delayActive || pollNote))
    else $error("abort wrong for poll kind");
  a_arm_cause: assert property ($rose(armed) |-> s_axi_bvalid || $past(handlerReturn))
    else $error("armed without write or return");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // ppi_top_assertions
`default_nettype wire

// ---- dv/ppi_top_tb_top.sv ----
// Self-checking bench of the polled pattern interrupt unit
`timescale 1ns/100ps
`default_nettype none
module ppi_top_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] inPort = 8'h5a;
  logic [7:0] hdlLen = 8'h04;
  logic [1:0] mode = 2'd0;
  logic pollCmd, pollNote, delayActive, handlerReturn, intCall, delayAbort, armed, irq;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [33:0] expRd[$];
  logic expAb[$];
  int error_cnt = 0;
  int n_compared = 0;
  logic [7:0] c, m;
  int i;
  // Clock at 40 MHz
  always #12.5 ref_clk = ~ref_clk;
  ppi_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .inPort(inPort), .pollCmd(pollCmd),
    .pollNote(pollNote), .delayActive(delayActive), .handlerReturn(handlerReturn),
    .intCall(intCall), .delayAbort(delayAbort), .armed(armed), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  ppi_core_model u_core (.ref_clk(ref_clk), .rst_n(rst_n), .intCall(intCall), .delayAbort(delayAbort),
    .mode(mode), .hdlLen(hdlLen), .pollCmd(pollCmd), .pollNote(pollNote),
    .delayActive(delayActive), .handlerReturn(handlerReturn));
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge ref_clk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge ref_clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    chk("bresp", {32'h0, s_axi_bresp}, {32'h0, ppi_pkg::RESP_OKAY});
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [33:0] e);
    @(posedge ref_clk);
    expRd.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  // Compare value goes in the low byte, mask in the next
  task cfg(input logic [7:0] cv, input logic [7:0] mv);
    wr(ppi_pkg::OFS_CFG, {16'h0, mv, cv});
  endtask
  task waitq(input int lim);
    int k;
    for (k = 0; k < lim && expAb.size() != 0; k++) @(posedge ref_clk);
    @(posedge ref_clk);
    chk("calls outstanding", 34'(expAb.size()), 34'h0);
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Monitor: read data and calls against the oldest note
  always @(posedge ref_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk("rresp and rdata", {s_axi_rresp, s_axi_rdata}, expRd.pop_front());
    end
    if (intCall === 1'b1) begin
      chk("delayAbort", {33'h0, delayAbort}, expAb.size() > 0 ? {33'h0, expAb.pop_front()} : 34'h2);
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h5acfa533));
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Reset values and register map
    chk("armed", {33'h0, armed}, 34'h0);
    rd(ppi_pkg::OFS_CFG, 34'h0);
    rd(ppi_pkg::OFS_STAT, {18'h0, inPort, 8'h00});
    rd(ppi_pkg::OFS_IRQST, 34'h0);
    rd(ppi_pkg::OFS_IRQMSK, 34'h0);
    rd(4'h2, {ppi_pkg::RESP_SLVERR, 32'h0});
    wr(ppi_pkg::OFS_IRQMSK, 32'h3);
    rd(ppi_pkg::OFS_IRQMSK, 34'h3);
    $display("test reset finished");
    // Random patterns on each poll kind
    for (i = 1; i < 4; i++) begin
      m = 8'($urandom) | 8'h01;
      c = 8'($urandom);
      mode <= 2'd0;
      inPort <= (c & m) | (8'($urandom) & ~m);
      cfg(c, m);
      repeat (4) @(posedge ref_clk);
      expAb.push_back(i != 1);
      mode <= 2'(i);
      waitq(20);
      chk("irq", {33'h0, irq}, 34'h1);
      repeat (12) @(posedge ref_clk);
      chk("armed", {33'h0, armed}, 34'h0);
      rd(ppi_pkg::OFS_IRQST, {32'h0, i != 1, 1'b1});
      chk("irq", {33'h0, irq}, 34'h0);
    end
    $display("test patterns finished");
    // Replacement and zero mask
    mode <= 2'd1;
    inPort <= 8'h04;
    wr(ppi_pkg::OFS_IRQMSK, 32'h2);
    cfg(8'h80, 8'h84);
    cfg(8'h01, 8'h01);
    inPort <= 8'h80;
    repeat (6) @(posedge ref_clk);
    cfg(8'h00, 8'h00);
    chk("armed", {33'h0, armed}, 34'h0);
    inPort <= 8'h81;
    repeat (6) @(posedge ref_clk);
    expAb.push_back(1'b0);
    cfg(8'h01, 8'h01);
    waitq(20);
    chk("irq", {33'h0, irq}, 34'h0);
    rd(ppi_pkg::OFS_IRQST, 34'h1);
    $display("test replace finished");
    // Re-arm inside the handler, match still true at return
    hdlLen <= 8'h28;
    repeat (8) @(posedge ref_clk);
    expAb.push_back(1'b0);
    cfg(8'h01, 8'h01);
    waitq(20);
    expAb.push_back(1'b0);
    cfg(8'h01, 8'h01);
    chk("armed", {33'h0, armed}, 34'h0);
    rd(ppi_pkg::OFS_CFG, 34'h0101);
    waitq(80);
    repeat (60) @(posedge ref_clk);
    $display("test rearm finished");
    tally_and_finish();
  end
endmodule // ppi_top_tb_top
bind ppi_top ppi_top_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .pollCmd(pollCmd),
  .pollNote(pollNote), .delayActive(delayActive), .handlerReturn(handlerReturn), .intCall(intCall),
  .delayAbort(delayAbort), .armed(armed), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));
`default_nettype wire
